// >>> hdl/touch_report_map.svh
`ifndef TOUCH_REPORT_MAP_SVH
`define TOUCH_REPORT_MAP_SVH
`define REPORT_ID_VAL 8'h01
`define REPORT_LEN 7'h3b
`define SLOT_LEN 4'hb
`define SLOT_BASE 7'h01
`define STAMP_LO_BYTE 7'h38
`define STAMP_HI_BYTE 7'h39
`define COUNT_BYTE 7'h3a
`define DETECT_BIT 0
`define ID_LSB 3
`define IDLE_DEFAULT 8'h02
`define IDLE_UNIT_MS 4
`define STAMP_HZ 10000
`define CLK_HZ 20000000
`endif

// >>> hdl/touch_report_pkg.sv
package touch_report_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOAD = 4'b0010,
    ST_SEND = 4'b0100,
    ST_NEXT = 4'b1000
  } framer_state_t;
endpackage

// >>> hdl/touch_slot_mem.sv
`timescale 1ns/1ns
// small table of touch records, registered read port
module touch_slot_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4,
  parameter int W = 49
) (
  input wire logic i_ref_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [W-1:0] o_rdata
);
  logic [W-1:0] mem [DEPTH];

  // no reset on storage; reads are registered
  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

// >>> hdl/touch_hid_report_framer.sv
`timescale 1ns/1ns
`include "touch_report_map.svh"
// Function
// - byte 0 of every report holds the fixed report identifier 0x01
// - geometry enable selects full or reduced slot layout
// - slot byte 1 bit 0 is detect flag, reserved bits, id on top
// - touch identifiers are numbered starting at one
// - X and Y are 12 bits, low byte first, high nibble zero
// - geometry on: X, X copy, Y, Y copy at slot bytes 2-9
// - geometry on: width in slot byte 10, height in byte 11
// - geometry off: copies, width and height bytes are zero
// - five 11-byte slots occupy bytes 1 to 55
// - bytes 56-57 carry a 10 kHz scan timestamp
// - every packet of one frame carries the same timestamp
// - byte 58 active touch count in first packet, zero in later ones
// - any contact status change triggers a new report
// - idle delay set by host, default 2 meaning 8 ms
// - slots without an active touch are all zero
// - more than five touches spill into further frame packets
module touch_hid_report_framer #(
  parameter int MAX_TOUCH = 16,
  parameter int TW = 4,
  parameter int SLOTS = 5,
  parameter int IDLE_MS_CYCLES = `CLK_HZ / 1000
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_geometry_report_enable,
  input wire logic i_touch_we,
  input wire logic [TW-1:0] i_touch_index,
  input wire logic i_touch_detect,
  input wire logic [11:0] i_touch_x,
  input wire logic [11:0] i_touch_y,
  input wire logic [7:0] i_touch_width,
  input wire logic [7:0] i_touch_height,
  input wire logic [TW:0] i_active_count,
  input wire logic i_set_idle,
  input wire logic [7:0] i_idle_value,
  output logic [7:0] o_tx_data,
  output logic o_tx_valid,
  output logic o_tx_last,
  input wire logic i_tx_ready,
  output logic o_busy
);
  // record: detect, x, y, width, height, pad, index
  localparam int RW = 1 + 12 + 12 + 8 + 8 + 8;
  localparam int STAMP_DIV = `CLK_HZ / `STAMP_HZ;
  localparam int MS_PER_UNIT = `IDLE_UNIT_MS;

  touch_report_pkg::framer_state_t state;
  touch_report_pkg::framer_state_t next_state;

  logic [RW-1:0] mem_rdata;
  logic [TW-1:0] mem_raddr;
  logic [15:0] stamp_div;
  logic [15:0] stamp_now;
  logic [15:0] frame_stamp;
  logic [7:0] idle_value;
  logic [7:0] idle_units;
  logic [1:0] idle_ms;
  logic [15:0] idle_cyc;
  logic change_pend;
  logic [TW:0] frame_count;
  logic [TW:0] sent_touches;
  logic first_pkt;
  logic [6:0] byte_idx;
  logic [3:0] slot_byte;
  logic [2:0] slot_num;
  logic [TW-1:0] touch_ptr;
  logic [RW-1:0] rec;
  logic fetch_pend;
  logic [7:0] data_byte;

  // storage of the latest record per touch; id also kept for the slot status byte
  touch_slot_mem #(
    .DEPTH(MAX_TOUCH),
    .AW(TW),
    .W(RW)
  ) u_mem (
    .i_ref_clk(i_ref_clk),
    .i_we(i_touch_we),
    .i_waddr(i_touch_index),
    .i_wdata({i_touch_detect, i_touch_x, i_touch_y, i_touch_width, i_touch_height,
      4'h0, i_touch_index}),
    .i_raddr(mem_raddr),
    .o_rdata(mem_rdata)
  );

  // record fields
  wire rec_det = rec[48];
  wire [11:0] rec_x = rec[47:36];
  wire [11:0] rec_y = rec[35:24];
  wire [7:0] rec_w = rec[23:16];
  wire [7:0] rec_h = rec[15:8];
  wire [TW-1:0] rec_idx = rec[TW-1:0];
  wire [4:0] rec_id = 5'(rec_idx) + 5'h01;

  // a slot carries a touch only while touches remain to be sent
  wire slot_live = (sent_touches + (TW+1)'(slot_num)) < frame_count;
  wire in_slots = (byte_idx >= `SLOT_BASE) && (byte_idx < `STAMP_LO_BYTE);
  wire geo = i_geometry_report_enable;

  // per slot byte selection
  // bytes 4, 5 and 8 to 11 of a slot read zero in the reduced layout
  logic [7:0] slot_val;
  always_comb begin
    slot_val = 8'h00;
    unique case (slot_byte)
      4'h0: slot_val = {rec_id, 2'b00, rec_det};
      4'h1: slot_val = rec_x[7:0];
      4'h2: slot_val = {4'h0, rec_x[11:8]};
      4'h3: slot_val = geo ? rec_x[7:0] : 8'h00;
      4'h4: slot_val = geo ? {4'h0, rec_x[11:8]} : 8'h00;
      4'h5: slot_val = rec_y[7:0];
      4'h6: slot_val = {4'h0, rec_y[11:8]};
      4'h7: slot_val = geo ? rec_y[7:0] : 8'h00;
      4'h8: slot_val = geo ? {4'h0, rec_y[11:8]} : 8'h00;
      4'h9: slot_val = geo ? rec_w : 8'h00;
      4'ha: slot_val = geo ? rec_h : 8'h00;
      default: slot_val = 8'h00;
    endcase
  end

  // packet byte selection
  always_comb begin
    data_byte = 8'h00;
    if (byte_idx == 7'h00) begin
      data_byte = `REPORT_ID_VAL;
    end else if (in_slots) begin
      data_byte = slot_live ? slot_val : 8'h00;
    end else if (byte_idx == `STAMP_LO_BYTE) begin
      data_byte = frame_stamp[7:0];
    end else if (byte_idx == `STAMP_HI_BYTE) begin
      data_byte = frame_stamp[15:8];
    end else if (byte_idx == `COUNT_BYTE) begin
      data_byte = first_pkt ? 8'(frame_count) : 8'h00;
    end
  end

  // 10 kHz free running scan timestamp
  // wraps after about 6.5 s; a host only compares nearby frames
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stamp_div <= 16'h0000;
      stamp_now <= 16'h0000;
    end else if (stamp_div == 16'(STAMP_DIV - 1)) begin
      stamp_div <= 16'h0000;
      stamp_now <= stamp_now + 16'h0001;
    end else begin
      stamp_div <= stamp_div + 16'h0001;
    end
  end

  // idle rate: host value in 4 ms units, zero means no idle reports
  // limitation: a frame longer than the idle period is followed at once by the next
  wire ms_tick = (idle_cyc == 16'(IDLE_MS_CYCLES - 1));
  wire unit_tick = ms_tick && (idle_ms == 2'(MS_PER_UNIT - 1));
  wire idle_fire = (idle_value != 8'h00) && unit_tick && (idle_units + 8'h01 >= idle_value);
  // host setting; holds the default until the first set-idle request
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      idle_value <= `IDLE_DEFAULT;
    end else if (i_set_idle) begin
      idle_value <= i_idle_value;
    end
  end

  // idle timer restarts at the start of every frame
  // measured from frame start, so the period does not stretch with a stalling host
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      idle_cyc <= 16'h0000;
      idle_ms <= 2'b00;
      idle_units <= 8'h00;
    end else if (state == touch_report_pkg::ST_LOAD || i_set_idle || idle_fire) begin
      idle_cyc <= 16'h0000;
      idle_ms <= 2'b00;
      idle_units <= 8'h00;
    end else begin
      idle_cyc <= ms_tick ? 16'h0000 : idle_cyc + 16'h0001;
      idle_ms <= ms_tick ? idle_ms + 2'b01 : idle_ms;
      idle_units <= unit_tick ? idle_units + 8'h01 : idle_units;
    end
  end

  // change latch: a write during a frame is kept so it is not lost
  // a write in the cycle of frame start wins over the clear
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      change_pend <= 1'b0;
    end else if (i_touch_we) begin
      change_pend <= 1'b1;
    end else if (idle_fire) begin
      change_pend <= 1'b1;
    end else if (state == touch_report_pkg::ST_LOAD) begin
      change_pend <= 1'b0;
    end
  end

  // handshake and walk boundaries
  wire byte_go = o_tx_valid && i_tx_ready;
  wire pkt_end = byte_go && (byte_idx == `COUNT_BYTE);
  wire slot_end = byte_go && in_slots && (slot_byte == (`SLOT_LEN - 4'h1));
  wire more = (sent_touches + (TW+1)'(SLOTS)) < frame_count;
  // address the record the next fetch lands: slot 0 on frame start, the
  // following touch on a slot end; otherwise the registered read would
  // hand back the slot just finished
  wire [TW-1:0] ptr_step = touch_ptr + {{(TW-1){1'b0}}, 1'b1};
  assign mem_raddr = (state == touch_report_pkg::ST_LOAD) ? '0 :
    (slot_end ? ptr_step : touch_ptr);

  // framer sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      touch_report_pkg::ST_IDLE: if (change_pend) next_state = touch_report_pkg::ST_LOAD;
      touch_report_pkg::ST_LOAD: next_state = touch_report_pkg::ST_SEND;
      touch_report_pkg::ST_SEND: if (pkt_end) next_state = touch_report_pkg::ST_NEXT;
      touch_report_pkg::ST_NEXT: next_state = more ? touch_report_pkg::ST_SEND :
        touch_report_pkg::ST_IDLE;
      default: next_state = touch_report_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= touch_report_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // frame context: count and stamp frozen for the whole frame
  // a write landing mid-frame changes neither until the next frame
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      frame_stamp <= 16'h0000;
      frame_count <= '0;
      sent_touches <= '0;
      first_pkt <= 1'b0;
    end else if (state == touch_report_pkg::ST_LOAD) begin
      frame_stamp <= stamp_now;
      frame_count <= i_active_count;
      sent_touches <= '0;
      first_pkt <= 1'b1;
    end else if (state == touch_report_pkg::ST_NEXT) begin
      sent_touches <= sent_touches + (TW+1)'(SLOTS);
      first_pkt <= 1'b0;
    end
  end

  // byte walk; the memory read lags one cycle so each slot prefetches
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      byte_idx <= 7'h00;
      slot_byte <= 4'h0;
      slot_num <= 3'h0;
      touch_ptr <= '0;
      fetch_pend <= 1'b0;
      rec <= '0;
    end else begin
      fetch_pend <= (state == touch_report_pkg::ST_LOAD) || slot_end ||
        (state == touch_report_pkg::ST_NEXT);
      if (fetch_pend) begin
        rec <= mem_rdata;
      end
      if (state == touch_report_pkg::ST_LOAD) begin
        byte_idx <= 7'h00;
        touch_ptr <= '0;
        slot_num <= 3'h0;
        slot_byte <= 4'h0;
      end else if (state == touch_report_pkg::ST_NEXT) begin
        byte_idx <= 7'h00;
        slot_num <= 3'h0;
        slot_byte <= 4'h0;
      end else if (byte_go) begin
        byte_idx <= byte_idx + 7'h01;
        if (slot_end) begin
          slot_byte <= 4'h0;
          slot_num <= slot_num + 3'h1;
          touch_ptr <= ptr_step;
        end else if (in_slots) begin
          slot_byte <= slot_byte + 4'h1;
        end
      end
    end
  end

  // valid held off while a record fetch is in flight
  // trade-off: one dead cycle per slot instead of a second read port
  assign o_tx_valid = (state == touch_report_pkg::ST_SEND) && !fetch_pend;
  assign o_tx_last = o_tx_valid && (byte_idx == `COUNT_BYTE);
  assign o_busy = (state != touch_report_pkg::ST_IDLE);

  // data from a flop so the byte mux never reaches the pin
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_tx_data <= 8'h00;
    end else begin
      o_tx_data <= data_byte;
    end
  end
endmodule

// >>> tb/usb_host_sink.sv
`timescale 1ns/1ns
// host end of the interrupt-in pipe: takes report bytes, may stall
module usb_host_sink (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_slow,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready
);
  logic took;
  logic [1:0] ph;
  logic [7:0] q[$];
  initial begin
    took = 1'b0;
    ph = 2'h0;
    o_tx_ready = 1'b1;
  end
  // data lags its handshake by a cycle, so capture on the next edge
  always @(posedge i_ref_clk) begin
    if (took) q.push_back(i_tx_data);
    took <= i_tx_valid && o_tx_ready && !i_sys_rst;
    ph <= ph + 2'h1;
    o_tx_ready <= #2 !i_slow || ph == 2'h0; // slow mode: one byte in four cycles
  end
endmodule

// >>> tb/touch_hid_report_framer_asserts.sv
`timescale 1ns/1ns
// port-level checks; byte position is rebuilt from the handshakes
module touch_hid_report_framer_checker (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_geometry_report_enable,
  input wire logic i_touch_we,
  input wire logic i_tx_ready,
  input wire logic [7:0] o_tx_data,
  input wire logic o_tx_valid,
  input wire logic o_tx_last,
  input wire logic o_busy
);
  logic [6:0] idx;
  logic [6:0] tidx;
  logic took;
  wire hs = o_tx_valid && i_tx_ready;
  wire [6:0] sb = tidx - 7'h01;
  wire [3:0] off = 4'(sb % 7'h0b); // offset inside a touch slot
  wire in_slot = tidx >= 7'h01 && tidx <= 7'h37;
  // tidx names the byte now on o_tx_data (registered lag)
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      idx <= 7'h00;
      tidx <= 7'h00;
      took <= 1'b0;
    end else begin
      took <= hs;
      tidx <= idx;
      if (hs) idx <= o_tx_last ? 7'h00 : idx + 7'h01;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  packet_end_a: assert property (o_tx_last |-> o_tx_valid && idx == 7'h3a)
    else $error("last flag off byte 58");
  full_length_a: assert property (o_tx_valid && idx == 7'h3a |-> o_tx_last)
    else $error("byte 58 without last flag");
  last_holds_a: assert property (o_tx_last && !i_tx_ready |=> o_tx_last)
    else $error("last byte dropped before taken");
  valid_in_frame_a: assert property (o_tx_valid |-> o_busy)
    else $error("byte offered outside a frame");
  change_reports_a: assert property (i_touch_we && !o_busy
    |=> ##1 o_busy ##[2:3] o_tx_valid)
    else $error("touch change started no report");
  report_id_a: assert property (took && tidx == 7'h00 |-> o_tx_data == 8'h01)
    else $error("first byte not report id");
  pos_nibble_a: assert property (took && in_slot && !off[0] && off >= 4'h2 && off <= 4'h8
    |-> o_tx_data[7:4] == 4'h0)
    else $error("position high nibble not zero");
  reduced_zero_a: assert property (took && in_slot && !i_geometry_report_enable
    && (off == 4'h3 || off == 4'h4 || off >= 4'h7) |-> o_tx_data == 8'h00)
    else $error("reserved slot byte not zero");
  status_rsvd_a: assert property (took && in_slot && off == 4'h0 |-> o_tx_data[2:1] == 2'h0)
    else $error("slot status reserved bits set");
  cover property (took && tidx == 7'h3a);
  cover property (o_tx_valid && !i_tx_ready);
  cover property (took && in_slot && !i_geometry_report_enable);
endmodule
bind touch_hid_report_framer touch_hid_report_framer_checker touch_hid_report_framer_checker_i (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
  .i_geometry_report_enable(i_geometry_report_enable), .i_touch_we(i_touch_we),
  .i_tx_ready(i_tx_ready), .o_tx_data(o_tx_data), .o_tx_valid(o_tx_valid),
  .o_tx_last(o_tx_last), .o_busy(o_busy));

// >>> tb/touch_hid_report_framer_tb_top.sv
`timescale 1ns/1ns
module touch_hid_report_framer_tb_top;
  logic i_ref_clk, i_sys_rst, i_geometry_report_enable, i_touch_we, i_touch_detect;
  logic [3:0] i_touch_index;
  logic [11:0] i_touch_x, i_touch_y;
  logic [7:0] i_touch_width, i_touch_height, i_idle_value, o_tx_data;
  logic [4:0] i_active_count;
  logic i_set_idle, o_tx_valid, o_tx_last, i_tx_ready, o_busy, slow;
  int error_cnt = 0;
  int checks = 0;
  int n;
  // idle millisecond shortened to 20 cycles (80 per 4 ms unit) so idle reports come quickly
  touch_hid_report_framer #(.IDLE_MS_CYCLES(20)) touch_hid_report_framer_i (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_geometry_report_enable(i_geometry_report_enable), .i_touch_we(i_touch_we),
    .i_touch_index(i_touch_index), .i_touch_detect(i_touch_detect), .i_touch_x(i_touch_x),
    .i_touch_y(i_touch_y), .i_touch_width(i_touch_width), .i_touch_height(i_touch_height),
    .i_active_count(i_active_count), .i_set_idle(i_set_idle), .i_idle_value(i_idle_value),
    .o_tx_data(o_tx_data), .o_tx_valid(o_tx_valid), .o_tx_last(o_tx_last),
    .i_tx_ready(i_tx_ready), .o_busy(o_busy));
  usb_host_sink usb_host_sink_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_slow(slow),
    .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready));
  initial begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end
  task automatic tick(input int c);
    repeat (c) @(posedge i_ref_clk);
    #2;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [7:0] qb(input int i);
    return usb_host_sink_i.q[i];
  endfunction
  // expected slot byte o of record r; records carry fixed patterns
  function automatic logic [7:0] slot_b(input int r, input int o, input logic g);
    logic [11:0] x = 12'h8a0 + 12'(r);
    logic [11:0] y = 12'h35c + 12'(r);
    case (o)
      0: return {5'(r + 1), 2'h0, !r[0]};
      1, 3: return (o == 1 || g) ? x[7:0] : 8'h00;
      2, 4: return (o == 2 || g) ? {4'h0, x[11:8]} : 8'h00;
      5, 7: return (o == 5 || g) ? y[7:0] : 8'h00;
      6, 8: return (o == 6 || g) ? {4'h0, y[11:8]} : 8'h00;
      9: return g ? 8'h10 + 8'(r) : 8'h00;
      default: return g ? 8'h20 + 8'(r) : 8'h00;
    endcase
  endfunction
  task automatic put(input int r);
    i_touch_index = 4'(r);
    i_touch_detect = !r[0];
    i_touch_x = 12'h8a0 + 12'(r);
    i_touch_y = 12'h35c + 12'(r);
    i_touch_width = 8'h10 + 8'(r);
    i_touch_height = 8'h20 + 8'(r);
    i_touch_we = 1'b1;
    tick(1);
    i_touch_we = 1'b0;
    tick(1);
  endtask
  // wait until no frame runs for five cycles, then drop captured bytes
  task automatic settle();
    int quiet = 0;
    for (int k = 0; k < 3000 && quiet < 5; k++) begin
      tick(1);
      quiet = o_busy ? 0 : quiet + 1;
    end
    chk("settle", 16'(quiet >= 5), 16'h1);
    usb_host_sink_i.q.delete();
  endtask
  task automatic wait_bytes(input int c);
    for (int k = 0; k < 4000 && usb_host_sink_i.q.size() < c; k++) tick(1);
    chk("bytes", 16'(usb_host_sink_i.q.size() >= c), 16'h1);
  endtask
  task automatic chk_pkt(input int p, input int base, input int cnt, input logic g,
                         input logic [7:0] cb);
    int r;
    chk("report id", qb(p * 59), 16'h01);
    for (int b = 1; b < 56; b++) begin
      r = base + (b - 1) / 11;
      chk("slot byte", qb(p * 59 + b), r < cnt ? slot_b(r, (b - 1) % 11, g) : 8'h00);
    end
    chk("count byte", qb(p * 59 + 58), cb);
  endtask
  function automatic logic [15:0] stamp(input int p);
    return {qb(p * 59 + 57), qb(p * 59 + 56)};
  endfunction
  task automatic s_layout(input logic g);
    settle();
    i_geometry_report_enable = g;
    i_active_count = 5'h01;
    put(0);
    wait_bytes(59);
    chk_pkt(0, 0, 1, g, 8'h01);
  endtask
  // seven touches with a stalling host: spill into a second packet
  task automatic s_spill();
    settle();
    i_geometry_report_enable = 1'b1;
    i_active_count = 5'h07;
    slow = 1'b1;
    for (int r = 0; r < 7; r++) put(r);
    wait_bytes(118);
    chk_pkt(0, 0, 7, 1'b1, 8'h07);
    chk_pkt(1, 5, 7, 1'b1, 8'h00);
    chk("frame stamp", stamp(1), stamp(0));
    slow = 1'b0;
  endtask
  // cycles from a change frame start to the next idle frame start
  task automatic idle_gap(output int c);
    settle();
    i_active_count = 5'h01;
    put(0);
    for (c = 0; c < 400 && !o_busy; c++) tick(1);
    c = 0;
    while (c < 400 && o_busy) begin
      tick(1);
      c++;
    end
    while (c < 400 && !o_busy) begin
      tick(1);
      c++;
    end
  endtask
  task automatic set_idle(input logic [7:0] v);
    i_idle_value = v;
    i_set_idle = 1'b1;
    tick(1);
    i_set_idle = 1'b0;
  endtask
  task automatic s_idle();
    idle_gap(n);
    chk("default idle", 16'(n >= 160 && n <= 164), 16'h1);
    set_idle(8'h01);
    idle_gap(n);
    chk("idle 4ms", 16'(n >= 80 && n <= 84), 16'h1);
    set_idle(8'h00);
    idle_gap(n);
    chk("idle off", 16'(n), 16'h190);
  endtask
  // two reports 4000 cycles apart: two ticks of the 10 kHz stamp
  task automatic s_stamp();
    settle();
    put(0);
    tick(3998);
    put(0);
    wait_bytes(118);
    chk("stamp step", stamp(1) - stamp(0), 16'h0002);
  endtask
  initial begin
    {i_geometry_report_enable, i_touch_we, i_touch_detect, i_set_idle, slow} = '0;
    {i_touch_index, i_touch_x, i_touch_y, i_touch_width, i_touch_height} = '0;
    i_idle_value = 8'h00;
    i_active_count = 5'h00;
    i_sys_rst = 1'b1;
    tick(10);
    i_sys_rst = 1'b0;
    s_layout(1'b1);
    s_layout(1'b0);
    s_spill();
    s_idle();
    s_stamp();
    results();
  end
  // run needs well under 20000 cycles
  initial begin
    #(40000 * 50);
    error_cnt++;
    results();
  end
endmodule
